// *** include/srsce_cfg.svh ***
// Constants of the read and search command executor: opcodes, codes, offsets and bit positions.
// Assumes inclusion by the decoder, the executor and the testbench alike.
`ifndef SRSCE_CFG_SVH
`define SRSCE_CFG_SVH
`define SRSCE_OP_READ_EXT   8'h28
`define SRSCE_OP_SRCH_EQ    8'h31
`define SRSCE_BLK_LAST      10'h1FF
`define SRSCE_BLK_LEN32     32'h0000_0200
`define SRSCE_MAX_BLKS      9'h100
`define SRSCE_MAX_UNIT      3'h1
`define SRSCE_CAP_SZ_256    32'h0000_0100
`define SRSCE_CAP_SZ_512    32'h0000_0200
`define SRSCE_ST_GOOD       8'h00
`define SRSCE_ST_CHECK      8'h02
`define SRSCE_ST_COND_MET   8'h04
`define SRSCE_ST_LINKED     8'h10
`define SRSCE_ST_LINKED_FLG 8'h14
`define SRSCE_ST_RES_CONFL  8'h18
`define SRSCE_SK_NO_SENSE   4'h0
`define SRSCE_SK_ILLEGAL    4'h5
`define SRSCE_SK_EQUAL      4'hC
`define SRSCE_A_CDB0        8'h00
`define SRSCE_A_CDB1        8'h04
`define SRSCE_A_CDB2        8'h08
`define SRSCE_A_CTRL        8'h0C
`define SRSCE_A_STAT        8'h10
`define SRSCE_A_SENSE       8'h14
`define SRSCE_A_SINFO       8'h18
`define SRSCE_A_SADD        8'h1C
`define SRSCE_A_RSIZE       8'h20
`define SRSCE_A_FOFF        8'h24
`define SRSCE_A_NREC        8'h28
`define SRSCE_A_ARG         8'h2C
`define SRSCE_A_CAPL        8'h30
`define SRSCE_A_CAPS        8'h34
`define SRSCE_CTRL_START    0
`define SRSCE_CTRL_RCONF0   1
`define SRSCE_CTRL_RCONF1   2
`define SRSCE_CTRL_DISC     3
`define SRSCE_CTRL_SZ512    4
`define SRSCE_RESP_OKAY     2'b00
`define SRSCE_RESP_SLVERR   2'b10
`define SRSCE_CDB_BYTE(c, n) c[79 - 8 * (n) -: 8]
`endif

// *** include/srsce_pkg.sv ***
// Types shared by the read and search command executor and its decoder.
// Assumes nothing of its surroundings.
package srsce_pkg;
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_req  = 4'b0010,
		st_xfer = 4'b0100,
		st_fin  = 4'b1000
	} srsce_state_t;
	typedef enum logic [1:0] {
		fmt_fixed = 2'h0,
		fmt_vli1  = 2'h1,
		fmt_vli2  = 2'h2,
		fmt_vli4  = 2'h3
	} srsce_fmt_t;
	typedef logic [2:0] srsce_unit_t;
endpackage

// *** include/srsce_cdb_if.sv ***
// Carrier between the command executor and its descriptor decoder.
// Assumes the executor holds the ten descriptor bytes stable while a command runs.
`timescale 1ns/10ps
interface srsce_cdb_if;
	logic [79:0]             cdb;
	logic                    is_read;
	logic                    is_srch;
	srsce_pkg::srsce_unit_t  unit;
	logic                    relative_addr_flag;
	logic [31:0]             lba;
	logic [8:0]              nblk;
	logic                    link;
	logic                    flag;
	logic                    invert_match_flag;
	srsce_pkg::srsce_fmt_t   fmt;
	logic                    record_span_flag;
	logic                    bad;
	modport dec (input cdb, output is_read, is_srch, unit, relative_addr_flag, lba, nblk, link,
		flag, invert_match_flag, fmt, record_span_flag, bad);
	modport exe (output cdb, input is_read, is_srch, unit, relative_addr_flag, lba, nblk, link,
		flag, invert_match_flag, fmt, record_span_flag, bad);
endinterface

// *** core/srsce_cdb_decode.sv ***
// Field decoder for the extended read and equality search descriptor blocks.
// Assumes byte 00 of the descriptor sits in the top eight bits of the carried vector.
`timescale 1ns/10ps
`include "srsce_cfg.svh"
module srsce_cdb_decode (
	srsce_cdb_if.dec c
);
	import srsce_pkg::*;
	wire [7:0] b0 = `SRSCE_CDB_BYTE(c.cdb, 0);
	wire [7:0] b1 = `SRSCE_CDB_BYTE(c.cdb, 1);
	wire [7:0] b2 = `SRSCE_CDB_BYTE(c.cdb, 2);
	wire [7:0] b3 = `SRSCE_CDB_BYTE(c.cdb, 3);
	wire [7:0] b4 = `SRSCE_CDB_BYTE(c.cdb, 4);
	wire [7:0] b5 = `SRSCE_CDB_BYTE(c.cdb, 5);
	wire [7:0] b6 = `SRSCE_CDB_BYTE(c.cdb, 6);
	wire [7:0] b7 = `SRSCE_CDB_BYTE(c.cdb, 7);
	wire [7:0] b8 = `SRSCE_CDB_BYTE(c.cdb, 8);
	wire [7:0] b9 = `SRSCE_CDB_BYTE(c.cdb, 9);
	wire [8:0] rd_cnt = {b7[0], b8};
	wire       rsv_read;
	wire       rsv_srch;

	assign c.is_read            = b0 == `SRSCE_OP_READ_EXT;
	assign c.is_srch            = b0 == `SRSCE_OP_SRCH_EQ;
	assign c.unit               = b1[7:5];
	assign c.relative_addr_flag = b1[0];
	assign c.lba                = {b2, b3, b4, b5};
	assign c.nblk               = c.is_read ? rd_cnt : {1'b0, b8};
	assign c.link               = b9[0];
	assign c.flag               = b9[1];
	assign c.invert_match_flag  = b1[4];
	assign c.fmt                = srsce_fmt_t'(b1[3:2]);
	assign c.record_span_flag   = b1[1];
	// Reserved bits are checked per command; in byte 09, bits 7:6 are tolerated for read and only bit 7 for search.
	assign rsv_read = (b1[4:1] != 4'h0) | (b6 != 8'h00) | (b7[7:1] != 7'h00)
		| (b9[5:2] != 4'h0) | (rd_cnt > `SRSCE_MAX_BLKS);
	assign rsv_srch = (b2 != 8'h00) | (b6 != 8'h00) | (b7 != 8'h00) | (b9[6:2] != 5'h00);
	assign c.bad = !(c.is_read | c.is_srch) | (c.unit > `SRSCE_MAX_UNIT)
		| (c.is_read ? rsv_read : rsv_srch);
endmodule

// *** core/srsce_exec.sv ***
// Executor for the extended read and equality search commands, with an AXI4-Lite register file.
// Assumes a media engine that streams one 512-byte block per request and a host data-in path.
//
// Behaviour
// - Capacity block size reads as a big-endian count of 256 or 512.
// - Opcode 28 hex selects the extended read toward the initiator.
// - Read moves whole 512-byte blocks and stops after the requested count.
// - Read descriptor fields: unit, relative flag, big-endian address, byte 06 zero.
// - Reservation conflict ends the read with conflict status and no data.
// - Media error ends the read with check status and the matching sense key.
// - Relative address adds signed offset to last block; none gives illegal request.
// - Block count zero moves nothing; 1 to 256 moves exactly that many.
// - Flag matters only with link; both set requests an interrupt.
// - Linked success advances to the next command; every command returns status.
// - With disconnection enabled the bus may be released during the read.
// - Opcode 31 hex searches records for data equal to the argument.
// - Linked search success continues; relative base becomes the matching block.
// - Linked search that is not satisfied breaks the link with ending status.
// - Unlinked satisfied search ends with condition-met status.
// - After a match without the invert flag, sense gives key, valid address, block and record offset.
// - After no match, sense gives no-sense key; valid address is cleared, or set with the invert flag.
// - Invert flag makes the search succeed only when nothing matched.
// - Record format selects fixed records or 1, 2, 4-byte length prefixes.
// - Unspanned records stay in one block; with fixed records a too-short tail is skipped.
// - Search stops when records or blocks are used up.
// - First block starts at the first-record offset; later blocks at zero.
`timescale 1ns/10ps
`include "srsce_cfg.svh"
module srsce_exec (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output wire logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output wire logic                   s_axi_wready,
	output wire logic [1:0]             s_axi_bresp,
	output wire logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output wire logic                   s_axi_arready,
	output wire logic [31:0]            s_axi_rdata,
	output wire logic [1:0]             s_axi_rresp,
	output wire logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output wire logic                   med_req,
	output wire srsce_pkg::srsce_unit_t med_unit,
	output wire logic [31:0]            med_lba,
	input  wire logic                   med_valid,
	input  wire logic [7:0]             med_data,
	output wire logic                   med_ready,
	input  wire logic                   med_err,
	input  wire logic [3:0]             med_err_key,
	output wire logic                   din_valid,
	output wire logic [7:0]             din_data,
	input  wire logic                   din_ready,
	output wire logic                   bus_release,
	output wire logic                   cmd_done,
	output wire logic                   link_next,
	output wire logic                   flag_intr
);
	import srsce_pkg::*;

	srsce_cdb_if cdb_bus ();
	srsce_cdb_decode u_dec (
		.c (cdb_bus)
	);

	srsce_state_t st_ff;
	logic [31:0]  cdb0_ff, cdb1_ff, cdb2_ff, rsize_ff, foff_ff, nrec_ff, arg_ff, cap_last_ff;
	logic [4:0]   ctrl_ff;
	logic [7:0]   status_ff;
	logic         ok_ff, sat_ff, sense_addr_valid_bit_ff, flag_req_ff;
	logic [3:0]   sense_key_ff;
	logic [31:0]  sinfo_ff, sadd_ff, cur_lba_ff;
	logic [31:0]  last_lba_ff [2];
	logic [1:0]   have_last_ff;
	logic [8:0]   blk_left_ff;
	logic [9:0]   pos_ff, rec_start_ff;
	logic [31:0]  rec_pos_ff, rec_len_ff, nrec_left_ff, match_lba_ff, match_off_ff;
	logic         matched_ff, first_blk_ff, found_ff, skip_ff;
	logic         din_valid_ff;
	logic [7:0]   din_data_ff;
	logic         aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [7:0]   awaddr_ff;
	logic [31:0]  wdata_ff, rdata_ff;
	logic [3:0]   wstrb_ff;
	logic [1:0]   bresp_ff, rresp_ff;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8 * i +: 8] = val[8 * i +: 8];
			end
		end
		return res;
	endfunction

	// Register bus decode.
	wire busy   = st_ff != st_idle;
	wire wr_go  = aw_held_ff & w_held_ff & !bvalid_ff;
	wire wr_ok  = (awaddr_ff <= `SRSCE_A_CTRL) | ((awaddr_ff >= `SRSCE_A_RSIZE)
		& (awaddr_ff <= `SRSCE_A_CAPL));
	wire wr_al  = awaddr_ff[1:0] == 2'b00;
	wire wr_en  = wr_go & wr_ok & wr_al & !busy;
	wire rd_ok  = (s_axi_araddr <= `SRSCE_A_CAPS) & (s_axi_araddr[1:0] == 2'b00);
	wire start  = wr_en & (awaddr_ff == `SRSCE_A_CTRL) & wstrb_ff[0]
		& wdata_ff[`SRSCE_CTRL_START];
	wire [31:0] cap_size = ctrl_ff[`SRSCE_CTRL_SZ512] ? `SRSCE_CAP_SZ_512
		: `SRSCE_CAP_SZ_256;
	wire [31:0] stat_word = {21'h0, flag_req_ff, have_last_ff != 2'b00, busy, status_ff};
	wire [31:0] rd_word =
		(s_axi_araddr == `SRSCE_A_CDB0)  ? cdb0_ff :
		(s_axi_araddr == `SRSCE_A_CDB1)  ? cdb1_ff :
		(s_axi_araddr == `SRSCE_A_CDB2)  ? cdb2_ff :
		(s_axi_araddr == `SRSCE_A_CTRL)  ? {27'h0, ctrl_ff} :
		(s_axi_araddr == `SRSCE_A_STAT)  ? stat_word :
		(s_axi_araddr == `SRSCE_A_SENSE) ? {24'h0, sense_addr_valid_bit_ff, 3'h0, sense_key_ff} :
		(s_axi_araddr == `SRSCE_A_SINFO) ? sinfo_ff :
		(s_axi_araddr == `SRSCE_A_SADD)  ? sadd_ff :
		(s_axi_araddr == `SRSCE_A_RSIZE) ? rsize_ff :
		(s_axi_araddr == `SRSCE_A_FOFF)  ? foff_ff :
		(s_axi_araddr == `SRSCE_A_NREC)  ? nrec_ff :
		(s_axi_araddr == `SRSCE_A_ARG)   ? arg_ff :
		(s_axi_araddr == `SRSCE_A_CAPL)  ? cap_last_ff :
		(s_axi_araddr == `SRSCE_A_CAPS)  ? cap_size : 32'h0000_0000;

	// Command start decisions.
	wire        unit_sel = cdb_bus.unit[0];
	wire        rel_bad  = cdb_bus.relative_addr_flag & !have_last_ff[unit_sel];
	wire        res_bad  = cdb_bus.is_read & (unit_sel ? ctrl_ff[`SRSCE_CTRL_RCONF1]
		: ctrl_ff[`SRSCE_CTRL_RCONF0]);
	wire        no_xfer  = (cdb_bus.nblk == 9'h000) | (cdb_bus.is_srch & (nrec_ff == 32'h0));
	wire [31:0] start_lba = cdb_bus.relative_addr_flag ? last_lba_ff[unit_sel] + cdb_bus.lba
		: cdb_bus.lba;

	// Byte stream and search comparison.
	wire        in_xfer  = st_ff == st_xfer;
	wire        acc      = med_valid & med_ready;
	wire        s_acc    = acc & cdb_bus.is_srch;
	wire        blk_end  = acc & (pos_ff == `SRSCE_BLK_LAST);
	wire        last_blk = blk_left_ff == 9'h001;
	wire [2:0]  hdr      = (cdb_bus.fmt == fmt_vli4) ? 3'h4 : {1'b0, cdb_bus.fmt};
	wire [31:0] hdr32    = {29'h0, hdr};
	wire [31:0] pos32    = {22'h0, pos_ff};
	wire        rec_beg  = rec_pos_ff == 32'h0;
	wire        before_1 = first_blk_ff & (pos32 < foff_ff);
	wire        no_fit   = !cdb_bus.record_span_flag & (cdb_bus.fmt == fmt_fixed) & rec_beg
		& (pos32 + rsize_ff > `SRSCE_BLK_LEN32);
	wire        in_rec   = !skip_ff & !before_1 & !no_fit;
	wire [31:0] cmp_idx  = rec_pos_ff - hdr32;
	wire        in_cmp   = (rec_pos_ff >= hdr32) & (cmp_idx < 32'h4);
	wire [31:0] arg_sh   = arg_ff << {cmp_idx[1:0], 3'b000};
	wire        byte_eq  = !in_cmp | (med_data == arg_sh[31:24]);
	wire [31:0] eff_len  = (cdb_bus.fmt == fmt_fixed) ? rsize_ff
		: ((rec_pos_ff < hdr32) ? 32'hFFFF_FFFF : rec_len_ff);
	wire        rec_end  = in_rec & (rec_pos_ff + 32'h1 >= eff_len);
	wire        hit      = rec_end & matched_ff & byte_eq;
	wire        nrec_out = rec_end & (nrec_left_ff == 32'h1);
	wire        s_stop   = s_acc & ((hit & !cdb_bus.invert_match_flag) | nrec_out);
	wire        any_hit  = found_ff | (s_acc & hit);
	wire        s_sat    = cdb_bus.invert_match_flag ? !any_hit : any_hit;
	wire        xfer_end = s_stop | (blk_end & last_blk);
	wire [9:0]  this_beg = rec_beg ? pos_ff : rec_start_ff;
	wire        link_ok  = ok_ff & cdb_bus.link & !(cdb_bus.is_srch & !sat_ff);

	assign cdb_bus.cdb   = {cdb0_ff, cdb1_ff, cdb2_ff[31:16]};
	assign s_axi_awready = !aw_held_ff & !bvalid_ff;
	assign s_axi_wready  = !w_held_ff & !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign med_req       = st_ff == st_req;
	assign med_unit      = cdb_bus.unit;
	assign med_lba       = cur_lba_ff;
	// The read path stalls the media while the one-byte output stage is full and din_ready is low.
	assign med_ready     = in_xfer & (cdb_bus.is_srch | !din_valid_ff | din_ready);
	assign din_valid     = din_valid_ff;
	assign din_data      = din_data_ff;
	// The bus is given up only while waiting on the media, never mid-byte.
	assign bus_release   = ctrl_ff[`SRSCE_CTRL_DISC] & ((st_ff == st_req)
		| (in_xfer & !med_valid));
	assign cmd_done      = st_ff == st_fin;
	assign link_next     = cmd_done & link_ok;
	assign flag_intr     = cmd_done & link_ok & cdb_bus.flag;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0;
			wstrb_ff   <= 4'h0;
			bresp_ff   <= `SRSCE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= (wr_ok & wr_al) ? `SRSCE_RESP_OKAY : `SRSCE_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= `SRSCE_RESP_OKAY;
		end else if (s_axi_arvalid & !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_ok ? `SRSCE_RESP_OKAY : `SRSCE_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Software registers are frozen while a command runs so the decode stays stable.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cdb0_ff     <= 32'h0;
			cdb1_ff     <= 32'h0;
			cdb2_ff     <= 32'h0;
			ctrl_ff     <= 5'h00;
			rsize_ff    <= 32'h0;
			foff_ff     <= 32'h0;
			nrec_ff     <= 32'h0;
			arg_ff      <= 32'h0;
			cap_last_ff <= 32'h0;
		end else if (wr_en) begin
			unique case (awaddr_ff)
				`SRSCE_A_CDB0: cdb0_ff <= merge(cdb0_ff, wdata_ff, wstrb_ff);
				`SRSCE_A_CDB1: cdb1_ff <= merge(cdb1_ff, wdata_ff, wstrb_ff);
				`SRSCE_A_CDB2: cdb2_ff <= merge(cdb2_ff, wdata_ff, wstrb_ff);
				`SRSCE_A_CTRL: ctrl_ff <= wstrb_ff[0] ? {wdata_ff[4:1], 1'b0} : ctrl_ff;
				`SRSCE_A_RSIZE: rsize_ff <= merge(rsize_ff, wdata_ff, wstrb_ff);
				`SRSCE_A_FOFF: foff_ff <= merge(foff_ff, wdata_ff, wstrb_ff);
				`SRSCE_A_NREC: nrec_ff <= merge(nrec_ff, wdata_ff, wstrb_ff);
				`SRSCE_A_ARG: arg_ff <= merge(arg_ff, wdata_ff, wstrb_ff);
				default: cap_last_ff <= merge(cap_last_ff, wdata_ff, wstrb_ff);
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff        <= st_idle;
			ok_ff        <= 1'b0;
			sat_ff       <= 1'b0;
			cur_lba_ff   <= 32'h0;
			blk_left_ff  <= 9'h000;
			pos_ff       <= 10'h000;
			status_ff    <= `SRSCE_ST_GOOD;
			sense_key_ff <= `SRSCE_SK_NO_SENSE;
			sense_addr_valid_bit_ff      <= 1'b0;
			sinfo_ff     <= 32'h0;
			sadd_ff      <= 32'h0;
			flag_req_ff  <= 1'b0;
		end else begin
			unique case (st_ff)
				st_idle: if (start) begin
					sat_ff <= 1'b0;
					st_ff  <= st_fin;
					ok_ff  <= 1'b0;
					if (cdb_bus.bad | rel_bad) begin
						status_ff    <= `SRSCE_ST_CHECK;
						sense_key_ff <= `SRSCE_SK_ILLEGAL;
					end else if (res_bad) begin
						status_ff <= `SRSCE_ST_RES_CONFL;
					end else if (no_xfer) begin
						ok_ff  <= 1'b1;
						sat_ff <= cdb_bus.invert_match_flag;
					end else begin
						ok_ff       <= 1'b1;
						cur_lba_ff  <= start_lba;
						blk_left_ff <= cdb_bus.nblk;
						st_ff       <= st_req;
					end
				end
				st_req: begin
					pos_ff <= 10'h000;
					st_ff  <= st_xfer;
				end
				st_xfer: if (med_err) begin
					ok_ff        <= 1'b0;
					status_ff    <= `SRSCE_ST_CHECK;
					sense_key_ff <= med_err_key;
					st_ff        <= st_fin;
				end else if (acc) begin
					pos_ff <= pos_ff + 10'h001;
					if (blk_end) begin
						cur_lba_ff  <= cur_lba_ff + 32'h1;
						blk_left_ff <= blk_left_ff - 9'h001;
					end
					if (xfer_end) begin
						sat_ff <= s_sat;
						st_ff  <= st_fin;
					end else if (blk_end) begin
						st_ff <= st_req;
					end
				end
				st_fin: begin
					st_ff       <= st_idle;
					flag_req_ff <= link_ok & cdb_bus.flag;
					if (ok_ff) begin
						sense_addr_valid_bit_ff      <= cdb_bus.is_srch & sat_ff;
						sense_key_ff <= (cdb_bus.is_srch & sat_ff & !cdb_bus.invert_match_flag)
							? `SRSCE_SK_EQUAL : `SRSCE_SK_NO_SENSE;
						sinfo_ff     <= match_lba_ff;
						sadd_ff      <= match_off_ff;
						if (link_ok) begin
							status_ff <= cdb_bus.flag ? `SRSCE_ST_LINKED_FLG : `SRSCE_ST_LINKED;
						end else if (cdb_bus.is_srch & sat_ff & !cdb_bus.link) begin
							status_ff <= `SRSCE_ST_COND_MET;
						end else begin
							status_ff <= `SRSCE_ST_GOOD;
						end
					end else begin
						sense_addr_valid_bit_ff <= 1'b0;
					end
				end
				default: st_ff <= st_idle;
			endcase
		end
	end

	// A linked group ends on any command that does not continue it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_last_ff   <= 2'b00;
			last_lba_ff[0] <= 32'h0;
			last_lba_ff[1] <= 32'h0;
		end else if (cmd_done & !link_ok) begin
			have_last_ff <= 2'b00;
		end else if (in_xfer & ((blk_end & !cdb_bus.is_srch) | (s_acc & hit & !found_ff))) begin
			have_last_ff[unit_sel] <= 1'b1;
			last_lba_ff[unit_sel]  <= cur_lba_ff;
		end else if (in_xfer & blk_end & !found_ff) begin
			have_last_ff[unit_sel] <= 1'b1;
			last_lba_ff[unit_sel]  <= cur_lba_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			din_valid_ff <= 1'b0;
			din_data_ff  <= 8'h00;
		end else if (acc & cdb_bus.is_read) begin
			din_valid_ff <= 1'b1;
			din_data_ff  <= med_data;
		end else if (din_ready) begin
			din_valid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | start) begin
			rec_pos_ff   <= 32'h0;
			rec_len_ff   <= 32'h0;
			matched_ff   <= 1'b1;
			nrec_left_ff <= nrec_ff;
			first_blk_ff <= 1'b1;
			found_ff     <= 1'b0;
			skip_ff      <= 1'b0;
			rec_start_ff <= 10'h000;
			match_lba_ff <= 32'h0;
			match_off_ff <= 32'h0;
		end else if (s_acc) begin
			if (in_rec & rec_end) begin
				rec_pos_ff   <= 32'h0;
				matched_ff   <= 1'b1;
				nrec_left_ff <= nrec_left_ff - 32'h1;
				if (hit & !found_ff) begin
					found_ff     <= 1'b1;
					match_lba_ff <= cur_lba_ff;
					match_off_ff <= {22'h0, this_beg};
				end
			end else if (in_rec) begin
				rec_pos_ff <= rec_pos_ff + 32'h1;
				matched_ff <= matched_ff & byte_eq;
				if (rec_pos_ff < hdr32) begin
					rec_len_ff <= {(rec_beg ? 24'h0 : rec_len_ff[23:0]), med_data};
				end
			end
			if (in_rec & rec_beg) begin
				rec_start_ff <= pos_ff;
			end
			if (no_fit) begin
				skip_ff <= 1'b1;
			end
			if (blk_end) begin
				first_blk_ff <= 1'b0;
				skip_ff      <= 1'b0;
				if (!cdb_bus.record_span_flag) begin
					rec_pos_ff <= 32'h0;
					matched_ff <= 1'b1;
				end
			end
		end
	end
endmodule

// *** tb/srsce_asserts.sv ***
// Checker of the executor's media, completion and register-bus handshakes.
// Assumes it is bound to the executor top and sees only its ports.
`timescale 1ns/10ps
module srsce_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic med_req,
	input wire logic med_ready,
	input wire logic med_err,
	input wire logic cmd_done,
	input wire logic link_next,
	input wire logic flag_intr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_req_single: assert property (med_req |=> !med_req) else $error("long request");
	a_req_quiet: assert property (med_req |-> !med_ready) else $error("early byte");
	a_done_single: assert property (cmd_done |=> !cmd_done) else $error("long done");
	a_link_done: assert property (link_next |-> cmd_done) else $error("stray link");
	a_flag_link: assert property (flag_intr |-> link_next) else $error("stray flag");
	a_err_ends: assert property (med_err && med_ready |-> ##[1:2] cmd_done) else $error("late");
	a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b");
	a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
	c_flag: cover property (flag_intr);
	c_err: cover property (med_err && med_ready);
	c_link: cover property (link_next && !flag_intr);
endmodule
bind srsce_exec srsce_chk chk_u (.*);

// *** tb/srsce_med.sv ***
// Media engine model: 512 bytes per block request, pausing after every fourth byte.
// Assumes the block address holds steady while a block streams.
`timescale 1ns/10ps
module srsce_med (
	input  wire logic        aclk,
	input  wire logic        med_req,
	input  wire logic        med_ready,
	input  wire logic [31:0] med_lba,
	input  wire logic [9:0]  err_at,
	output wire logic        med_valid,
	output wire logic [7:0]  med_data,
	output wire logic        med_err
);
	logic [9:0] cnt_ff = 10'h200;
	logic       gap_ff = 1'h0;
	always_ff @(posedge aclk) begin
		cnt_ff <= med_req ? 10'h000 : cnt_ff + 10'(med_valid && med_ready);
		gap_ff <= med_valid && med_ready && cnt_ff[1:0] == 2'h3;
	end
	assign med_valid = !cnt_ff[9] && !gap_ff;
	// Idle data is inverted so a byte taken outside valid cannot match by chance.
	assign med_data = med_valid ? cnt_ff[7:0] ^ med_lba[7:0] : ~cnt_ff[7:0];
	assign med_err = med_valid && cnt_ff == err_at;
endmodule

// *** tb/testbench.sv ***
// Bench: register tasks over AXI4-Lite run read and search commands.
// Assumes the media model stands on the far side of the executor.
`timescale 1ns/10ps
`include "srsce_cfg.svh"
module testbench;
	logic        aclk = 1'h0, aresetn = 1'h0, din_ready = 1'h1, done = 1'h0, lnk, rd_mode = 1'h1;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, flg, rel = 1'h0;
	logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, v, nbytes = 32'h0, base = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF, med_err_key = 4'h3;
	logic [9:0]  err_at = 10'h3FF;
	logic [1:0]  rsp, bsp;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata, med_lba;
	wire logic [7:0]  med_data, din_data;
	wire srsce_pkg::srsce_unit_t med_unit;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, med_req;
	wire logic med_valid, med_ready, med_err, din_valid, bus_release, cmd_done, link_next, flag_intr;
	int mismatches = 0, num_checks = 0, cyc = 0;
	srsce_exec dut_u (.*);
	srsce_med med_u (.*);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		din_ready <= cyc % 4 != 0;
		if (din_valid && din_ready) begin
			if (rd_mode) chk("din", 32'(din_data), 32'(nbytes[7:0] ^ (base[7:0] + nbytes[16:9])));
			nbytes <= nbytes + 32'h1;
		end
		if (cmd_done) {done, lnk, flg} <= {1'h1, link_next, flag_intr};
		if (bus_release) rel <= 1'h1;
		if (med_req) chk("unit", 32'(med_unit), 32'h0);
		if (cyc == 40000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		bsp = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		{s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		{v, rsp} = {s_axi_rdata, s_axi_rresp};
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), v, e);
	endtask
	task automatic cmd(input logic [31:0] c0, c1, c2, ct, st, nb);
		int n;
		wr(`SRSCE_A_CDB0, c0);
		wr(`SRSCE_A_CDB1, c1);
		wr(`SRSCE_A_CDB2, c2);
		// The start decision sees the old control word, so the control bits go in first.
		wr(`SRSCE_A_CTRL, ct);
		{nbytes, done, rel} <= 34'h0;
		wr(`SRSCE_A_CTRL, ct | 32'h1);
		for (n = 0; n < 9000 && !done; n++) @(posedge aclk);
		chk("done", 32'(done), 32'h1);
		rd(`SRSCE_A_STAT);
		chk("status", v & 32'hFF, st);
		if (nb != 32'hFFFFFFFF) chk("bytes", nbytes, nb);
		$display("command %h finished", c0[31:24]);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc(`SRSCE_A_CAPS, `SRSCE_CAP_SZ_256);
		wr(`SRSCE_A_CTRL, 32'h10);
		rc(`SRSCE_A_CAPS, `SRSCE_CAP_SZ_512);
		rc(8'h40, 32'h0);
		chk("rresp", 32'(rsp), 32'h2);
		wr(8'h40, 32'h0);
		chk("bresp", 32'(bsp), 32'h2);
		base <= 32'h10;
		cmd(32'h28000000, 32'h00100000, 32'h02000000, 32'h8, 32'h0, 32'h400);
		chk("release", 32'(rel), 32'h1);
		base <= 32'h30;
		cmd(32'h28000000, 32'h00300000, 32'h01030000, 32'h0, 32'h14, 32'h200);
		chk("link flag", {30'h0, lnk, flg}, 32'h3);
		chk("no release", 32'(rel), 32'h0);
		base <= 32'h2E;
		cmd(32'h2801FFFF, 32'hFFFE0000, 32'h01010000, 32'h0, 32'h10, 32'h200);
		cmd(32'h28210000, 32'h0, 32'h01000000, 32'h0, 32'h2, 32'h0);
		rc(`SRSCE_A_SENSE, 32'h5);
		cmd(32'h28000000, 32'h002E0000, 32'h01000000, 32'h2, 32'h18, 32'h0);
		cmd(32'h28000000, 32'h002E0100, 32'h01000000, 32'h0, 32'h2, 32'h0);
		cmd(32'h28000000, 32'h002E0000, 32'h00000000, 32'h0, 32'h0, 32'h0);
		err_at <= 10'h00A;
		cmd(32'h28000000, 32'h002E0000, 32'h01000000, 32'h0, 32'h2, 32'hFFFFFFFF);
		rc(`SRSCE_A_SENSE, 32'h3);
		{err_at, rd_mode} <= {10'h3FF, 1'h0};
		wr(`SRSCE_A_RSIZE, 32'h8);
		wr(`SRSCE_A_NREC, 32'h40);
		wr(`SRSCE_A_ARG, 32'h08090A0B);
		cmd(32'h31000000, 32'h0, 32'h01000000, 32'h0, 32'h4, 32'hFFFFFFFF);
		rc(`SRSCE_A_SENSE, 32'h8C);
		rc(`SRSCE_A_SADD, 32'h8);
		wr(`SRSCE_A_ARG, 32'hFFFFFFFF);
		cmd(32'h31000000, 32'h0, 32'h01010000, 32'h0, 32'h0, 32'hFFFFFFFF);
		rc(`SRSCE_A_SENSE, 32'h0);
		chk("link", 32'(lnk), 32'h0);
		cmd(32'h31100000, 32'h0, 32'h01000000, 32'h0, 32'h4, 32'hFFFFFFFF);
		rc(`SRSCE_A_SENSE, 32'h80);
		wr(`SRSCE_A_ARG, 32'h08090A0B);
		cmd(32'h31000000, 32'h0, 32'h01010000, 32'h0, 32'h10, 32'hFFFFFFFF);
		{base, rd_mode} <= {32'h3, 1'h1};
		cmd(32'h28010000, 32'h00030000, 32'h01000000, 32'h0, 32'h0, 32'h200);
		report_and_stop();
	end
endmodule
